/* File: design/coe_pkg.sv */
// Package of constants and types for the core operation subset executor
package coe_pkg;
    localparam int DATA_W = 8;
    localparam int FILE_IDX_W = 7;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OPER_OFS = 8'h04;
    localparam logic [7:0] ACC_OFS = 8'h08;
    localparam logic [7:0] FLAGS_OFS = 8'h0c;
    localparam logic [7:0] PC_OFS = 8'h10;
    localparam logic [7:0] FILE_OFS = 8'h14;
    localparam logic [7:0] PUSH_OFS = 8'h18;
    // Command word layout in the operand register
    localparam int OPC_LSB = 0;
    localparam int TGT_BIT = 3;
    localparam int IDX_LSB = 8;
    localparam int IMM_LSB = 16;
    // Flags register layout
    localparam int ZERO_BIT = 0;
    localparam int CARRY_BIT = 1;
    localparam int IRQ_ALLOW_BIT = 2;
    localparam int BUSY_BIT = 3;
    // Reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    // Cycle counts and AXI response codes
    localparam logic [1:0] ONE_CYCLE = 2'h1;
    localparam logic [1:0] TWO_CYCLE = 2'h2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        COE_IDLE_OP = 3'b000,
        COE_INCREMENT_REG_OP = 3'b001,
        COE_OR_ACC_INTO_REG_OP = 3'b010,
        COE_LOAD_IMM_ACC_OP = 3'b011,
        COE_IRQ_RETURN_OP = 3'b100,
        COE_STORE_ACC_OP = 3'b101,
        COE_RETURN_IMM_OP = 3'b110,
        COE_ROTATE_LEFT_CARRY_OP = 3'b111
    } coe_op_t;

    typedef enum logic [1:0] {
        COE_ST_READY = 2'b00,
        COE_ST_EXEC = 2'b01,
        COE_ST_WAIT = 2'b10
    } coe_state_t;
endpackage

/* File: design/coe_alu_if.sv */
// Interface carrying operands and results between executor and ALU
interface coe_alu_if;
    import coe_pkg::*;
    coe_op_t op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] file_val;
    logic [DATA_W-1:0] imm;
    logic carry_in;
    logic [DATA_W-1:0] result;
    logic carry_out;
    logic zero_out;
    logic write_zero;
    logic write_carry;
    modport ctrl (output op, output acc, output file_val, output imm, output carry_in,
                  input result, input carry_out, input zero_out, input write_zero, input write_carry);
    modport alu (input op, input acc, input file_val, input imm, input carry_in,
                 output result, output carry_out, output zero_out, output write_zero, output write_carry);
endinterface

/* File: design/coe_alu.sv */
// Combinational result and flag logic of the operation subset
module coe_alu
    import coe_pkg::*;
(
    coe_alu_if.alu bus
);
    always_comb begin
        bus.result = bus.acc;
        bus.carry_out = bus.carry_in;
        bus.write_zero = 1'b0;
        bus.write_carry = 1'b0;
        unique case (bus.op)
            COE_INCREMENT_REG_OP: begin
                bus.result = bus.file_val + 8'h01;
                bus.write_zero = 1'b1;
            end
            COE_OR_ACC_INTO_REG_OP: begin
                bus.result = bus.acc | bus.file_val;
                bus.write_zero = 1'b1;
            end
            COE_LOAD_IMM_ACC_OP: begin
                bus.result = bus.imm;
            end
            COE_RETURN_IMM_OP: begin
                bus.result = bus.imm;
            end
            COE_STORE_ACC_OP: begin
                bus.result = bus.acc;
            end
            COE_ROTATE_LEFT_CARRY_OP: begin
                bus.result = {bus.file_val[DATA_W-2:0], bus.carry_in};
                bus.carry_out = bus.file_val[DATA_W-1];
                bus.write_carry = 1'b1;
            end
            COE_IDLE_OP, COE_IRQ_RETURN_OP: begin
                bus.result = bus.acc;
            end
        endcase
        bus.zero_out = (bus.result == 8'h00);
    end
endmodule

/* File: design/coe_stack.sv */
// Return address stack held in flip-flops
module coe_stack
    import coe_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [PC_W-1:0] push_val_i,
    output logic [PC_W-1:0] top_o
);
    logic [PC_W-1:0] mem_reg [DEPTH];
    logic [PC_W-1:0] mem_next [DEPTH];
    logic [STACK_PTR_W-1:0] ptr_reg;
    logic [STACK_PTR_W-1:0] ptr_next;

    // Circular stack: overflow wraps silently
    always_comb begin
        mem_next = mem_reg;
        ptr_next = ptr_reg;
        if (push_i) begin
            mem_next[ptr_reg] = push_val_i;
            ptr_next = ptr_reg + 3'h1;
        end else if (pop_i) begin
            ptr_next = ptr_reg - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ptr_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            ptr_reg <= ptr_next;
            mem_reg <= mem_next;
        end
    end

    assign top_o = mem_reg[ptr_reg - 3'h1];
endmodule

/* File: design/coe_core.sv */
// Top level: operation subset executor with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
module coe_core
    import coe_pkg::*;
// Behaviour
// - Increment adds one to file register, result to destination, only zero flag changes.
// - Target bit 0 writes accumulator, 1 writes back to the file register.
// - OR of accumulator and file register to destination, only zero flag changes.
// - Load immediate puts eight-bit operand in accumulator, flags untouched.
// - Interrupt return pops stack top into PC and sets interrupt allow bit.
// - Store copies accumulator into addressed file register, flags untouched.
// - Return with immediate loads operand into accumulator, flags untouched.
// - Return with immediate also pops stack top into PC.
// - Return with immediate takes two instruction cycles.
// - Rotate left through carry, result to destination chosen by target bit.
// - Register operations take index 0..127 and a one-bit target selector.
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic GLOBAL_IRQ_ALLOW_O,
    output logic BUSY_O
);
    coe_alu_if alu_bus ();

    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    // Ready and busy outputs are kept in flops of their own
    logic aw_ready_reg, w_ready_reg, ar_ready_reg, busy_reg;

    logic [DATA_W-1:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic carry_reg, carry_next;
    logic irq_allow_reg, irq_allow_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [31:0] oper_reg, oper_next;
    logic [FILE_IDX_W-1:0] file_sel_reg, file_sel_next;
    logic [DATA_W-1:0] file_reg [FILE_DEPTH];
    logic [DATA_W-1:0] file_next [FILE_DEPTH];
    coe_state_t state_reg, state_next;
    logic [1:0] cyc_reg, cyc_next;

    logic push_en, pop_en;
    logic [PC_W-1:0] stack_top;
    logic do_write;
    logic do_read;
    logic start_op;

    coe_op_t cur_op;
    logic cur_tgt;
    logic [FILE_IDX_W-1:0] cur_idx;
    logic [DATA_W-1:0] cur_imm;

    assign cur_op = coe_op_t'(oper_reg[OPC_LSB +: 3]);
    assign cur_tgt = oper_reg[TGT_BIT];
    assign cur_idx = oper_reg[IDX_LSB +: FILE_IDX_W];
    assign cur_imm = oper_reg[IMM_LSB +: DATA_W];

    assign alu_bus.op = cur_op;
    assign alu_bus.acc = acc_reg;
    assign alu_bus.file_val = file_reg[cur_idx];
    assign alu_bus.imm = cur_imm;
    assign alu_bus.carry_in = carry_reg;

    coe_alu u_alu (
        .bus(alu_bus)
    );

    coe_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .ref_clk_i(REF_CLK_I),
        .rst_b_i(RST_B_I),
        .push_i(push_en),
        .pop_i(pop_en),
        .push_val_i(pc_reg),
        .top_o(stack_top)
    );

    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign do_read = S_AXI_ARVALID_I && !rvalid_reg;
    assign start_op = do_write && (aw_addr_reg == CTRL_OFS) && w_strb_reg[0] && w_data_reg[0]
                      && (state_reg == COE_ST_READY);

    // AXI4-Lite slave: address and data captured independently
    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (S_AXI_AWVALID_I && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = S_AXI_WDATA_I;
            w_strb_next = S_AXI_WSTRB_I;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            unique case (aw_addr_reg)
                CTRL_OFS, OPER_OFS, ACC_OFS, FLAGS_OFS, PC_OFS, FILE_OFS, PUSH_OFS: bresp_next = AXI_OKAY;
                default: bresp_next = AXI_SLVERR;
            endcase
        end else if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_next = 1'b0;
        end
        if (do_read) begin
            rvalid_next = 1'b1;
            rresp_next = AXI_OKAY;
            rdata_next = '0;
            unique case (S_AXI_ARADDR_I)
                CTRL_OFS: rdata_next = {30'h0, state_reg != COE_ST_READY, 1'b0};
                OPER_OFS: rdata_next = oper_reg;
                ACC_OFS: rdata_next = {24'h0, acc_reg};
                FLAGS_OFS: rdata_next = {28'h0, state_reg != COE_ST_READY, irq_allow_reg, carry_reg, zero_reg};
                PC_OFS: rdata_next = {19'h0, pc_reg};
                FILE_OFS: rdata_next = {17'h0, file_sel_reg, file_reg[file_sel_reg]};
                PUSH_OFS: rdata_next = {19'h0, stack_top};
                default: rresp_next = AXI_SLVERR;
            endcase
        end else if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_next = 1'b0;
        end
    end

    // Execution state and architectural registers
    always_comb begin
        acc_next = acc_reg;
        zero_next = zero_reg;
        carry_next = carry_reg;
        irq_allow_next = irq_allow_reg;
        pc_next = pc_reg;
        oper_next = oper_reg;
        file_sel_next = file_sel_reg;
        file_next = file_reg;
        state_next = state_reg;
        cyc_next = cyc_reg;
        push_en = 1'b0;
        pop_en = 1'b0;
        if (do_write && state_reg == COE_ST_READY) begin
            unique case (aw_addr_reg)
                OPER_OFS: oper_next = w_data_reg;
                ACC_OFS: acc_next = w_data_reg[DATA_W-1:0];
                FLAGS_OFS: begin
                    zero_next = w_data_reg[ZERO_BIT];
                    carry_next = w_data_reg[CARRY_BIT];
                    irq_allow_next = w_data_reg[IRQ_ALLOW_BIT];
                end
                PC_OFS: pc_next = w_data_reg[PC_W-1:0];
                FILE_OFS: begin
                    file_sel_next = w_data_reg[IDX_LSB +: FILE_IDX_W];
                    if (w_data_reg[31]) begin
                        file_next[w_data_reg[IDX_LSB +: FILE_IDX_W]] = w_data_reg[DATA_W-1:0];
                    end
                end
                PUSH_OFS: push_en = 1'b1;
                default: ;
            endcase
        end
        unique case (state_reg)
            COE_ST_READY: begin
                if (start_op) begin
                    state_next = COE_ST_EXEC;
                end
            end
            COE_ST_EXEC: begin
                pc_next = pc_reg + 13'h0001;
                cyc_next = (cur_op == COE_RETURN_IMM_OP || cur_op == COE_IRQ_RETURN_OP) ? TWO_CYCLE : ONE_CYCLE;
                state_next = COE_ST_WAIT;
                unique case (cur_op)
                    COE_INCREMENT_REG_OP, COE_OR_ACC_INTO_REG_OP, COE_ROTATE_LEFT_CARRY_OP: begin
                        if (cur_tgt) begin
                            file_next[cur_idx] = alu_bus.result;
                        end else begin
                            acc_next = alu_bus.result;
                        end
                    end
                    COE_LOAD_IMM_ACC_OP: acc_next = alu_bus.result;
                    COE_STORE_ACC_OP: file_next[cur_idx] = alu_bus.result;
                    COE_RETURN_IMM_OP: begin
                        acc_next = alu_bus.result;
                        pc_next = stack_top;
                        pop_en = 1'b1;
                    end
                    COE_IRQ_RETURN_OP: begin
                        pc_next = stack_top;
                        pop_en = 1'b1;
                        irq_allow_next = 1'b1;
                    end
                    COE_IDLE_OP: ;
                endcase
                if (alu_bus.write_zero) begin
                    zero_next = alu_bus.zero_out;
                end
                if (alu_bus.write_carry) begin
                    carry_next = alu_bus.carry_out;
                end
            end
            COE_ST_WAIT: begin
                // Hold busy for the instruction's cycle count
                cyc_next = cyc_reg - 2'h1;
                if (cyc_reg == ONE_CYCLE) begin
                    state_next = COE_ST_READY;
                end
            end
            default: state_next = COE_ST_READY;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_B_I) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= AXI_OKAY;
            rdata_reg <= '0;
            aw_ready_reg <= 1'b1;
            w_ready_reg <= 1'b1;
            ar_ready_reg <= 1'b1;
            busy_reg <= 1'b0;
            acc_reg <= ACC_RST;
            zero_reg <= 1'b0;
            carry_reg <= 1'b0;
            irq_allow_reg <= 1'b0;
            pc_reg <= PC_RST;
            oper_reg <= '0;
            file_sel_reg <= '0;
            state_reg <= COE_ST_READY;
            cyc_reg <= '0;
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_reg[i] <= '0;
            end
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            aw_ready_reg <= !aw_full_next;
            w_ready_reg <= !w_full_next;
            ar_ready_reg <= !rvalid_next;
            busy_reg <= (state_next != COE_ST_READY);
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            carry_reg <= carry_next;
            irq_allow_reg <= irq_allow_next;
            pc_reg <= pc_next;
            oper_reg <= oper_next;
            file_sel_reg <= file_sel_next;
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            file_reg <= file_next;
        end
    end

    assign S_AXI_AWREADY_O = aw_ready_reg;
    assign S_AXI_WREADY_O = w_ready_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_ARREADY_O = ar_ready_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign GLOBAL_IRQ_ALLOW_O = irq_allow_reg;
    assign BUSY_O = busy_reg;
endmodule

/* File: tb/coe_core_chk.sv */
// Port-level assertion checker for the operation subset executor
module coe_core_chk
    import coe_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic GLOBAL_IRQ_ALLOW_O,
    input wire logic BUSY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] op_reg;
    logic [2:0] op_next;
    logic [7:0] ar_reg;
    logic [7:0] ar_next;
    logic ret_op;
    logic wr_take;

    assign wr_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign ret_op = op_reg == COE_IRQ_RETURN_OP || op_reg == COE_RETURN_IMM_OP;

    // Remembers the last operation code written and the last read address
    always_comb begin
        op_next = op_reg;
        ar_next = ar_reg;
        if (wr_take && S_AXI_AWADDR_I == OPER_OFS) op_next = S_AXI_WDATA_I[2:0];
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) ar_next = S_AXI_ARADDR_I;
        if (!RST_B_I) begin
            op_next = 3'h0;
            ar_next = 8'h00;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        op_reg <= op_next;
        ar_reg <= ar_next;
    end

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_idle_busy_len: assert property ($rose(BUSY_O) && !ret_op |-> BUSY_O[*2] ##1 !BUSY_O)
        else $error("busy length wrong for single cycle operation");
    a_ret_busy_len: assert property ($rose(BUSY_O) && op_reg == COE_RETURN_IMM_OP |-> BUSY_O[*3] ##1 !BUSY_O)
        else $error("busy length wrong for return with immediate");
    a_irq_allow_set: assert property ($fell(BUSY_O) && op_reg == COE_IRQ_RETURN_OP |-> GLOBAL_IRQ_ALLOW_O)
        else $error("interrupt allow not set by interrupt return");
    a_irq_allow_keep: assert property ($fell(BUSY_O) && !ret_op |->
        GLOBAL_IRQ_ALLOW_O == $past(GLOBAL_IRQ_ALLOW_O, 3))
        else $error("interrupt allow changed by other operation");
    a_write_answer: assert property (wr_take |-> ##2 S_AXI_BVALID_O)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read answer late");
    a_read_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data not held");
    a_unmapped_read: assert property (S_AXI_RVALID_O && ar_reg > PUSH_OFS |->
        S_AXI_RRESP_O == AXI_SLVERR && S_AXI_RDATA_O == 0)
        else $error("unmapped read answered wrongly");

    c_return_imm: cover property ($rose(BUSY_O) && op_reg == COE_RETURN_IMM_OP);
    c_irq_return: cover property ($rose(BUSY_O) && op_reg == COE_IRQ_RETURN_OP);
    c_rotate: cover property ($rose(BUSY_O) && op_reg == COE_ROTATE_LEFT_CARRY_OP);
endmodule

bind coe_core coe_core_chk u_chk (.*);

/* File: tb/coe_core_tb.sv */
// Self-checking bench for the operation subset executor
module coe_core_tb
    import coe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} coe_exp_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    wire awready, wready, bvalid, arready, rvalid, irq_allow, busy;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    coe_exp_t rq[$];
    logic [1:0] wq[$];
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] m_acc;
    logic m_z, m_c, m_g;
    logic [12:0] m_pc, m_top;

    coe_core dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .GLOBAL_IRQ_ALLOW_O(irq_allow), .BUSY_O(busy));

    always #20 clk = ~clk;

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic to_fail;
        fail_count++;
        complete_run();
    endtask

    // Oldest noted expectation is consumed when a response is handed over
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready) begin
            check(rdata & rq[0].m, rq[0].d);
            check({30'h0, rresp}, {30'h0, rq[0].r});
            void'(rq.pop_front());
        end
        if (bvalid === 1'b1 && bready) begin
            check({30'h0, bresp}, {30'h0, wq[0]});
            void'(wq.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
        int n;
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) to_fail();
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff,
                      input logic [1:0] r = AXI_OKAY);
        int n;
        rq.push_back('{d & m, m, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) to_fail();
        @(posedge clk);
    endtask

    task automatic run_op(input logic [2:0] op, input logic t, input logic [6:0] x, input logic [7:0] k);
        int n;
        int m;
        wr(OPER_OFS, {8'h0, k, 1'b0, x, 4'h0, t, op});
        wr(CTRL_OFS, 32'h1);
        for (n = 0; n < 8 && busy !== 1'b1; n++) @(posedge clk);
        for (m = 0; m < 8 && busy !== 1'b0; m++) @(posedge clk);
        if (n == 8 || m == 8) to_fail();
    endtask

    initial begin
        logic [2:0] op;
        logic t;
        logic [6:0] x;
        logic [7:0] f, k, r;
        int i;
        void'($urandom(15));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(ACC_OFS, {24'h0, ACC_RST}, 32'hff);
        rd(PC_OFS, {19'h0, PC_RST}, 32'h1fff);
        wr(8'h40, 32'h0, AXI_SLVERR);
        rd(8'h40, 32'h0, 32'hffffffff, AXI_SLVERR);
        for (i = 0; i < 32; i++) begin
            op = i[2:0];
            t = i[3];
            x = (i % 3 == 0) ? 7'h00 : (i % 3 == 1) ? 7'h7f : 7'($urandom);
            f = (i < 8) ? 8'hff : (i < 16) ? 8'h00 : 8'($urandom);
            k = 8'($urandom);
            m_acc = i[4] ? 8'($urandom) : 8'h00;
            m_z = 1'($urandom);
            m_c = 1'($urandom);
            m_g = 1'b0;
            m_top = 13'($urandom);
            m_pc = 13'($urandom);
            wr(FILE_OFS, {1'b1, 16'h0, x, f});
            wr(ACC_OFS, {24'h0, m_acc});
            wr(FLAGS_OFS, {29'h0, m_g, m_c, m_z});
            wr(PC_OFS, {19'h0, m_top});
            wr(PUSH_OFS, 32'h0);
            wr(PC_OFS, {19'h0, m_pc});
            rd(PUSH_OFS, {19'h0, m_top}, 32'h1fff);
            run_op(op, t, x, k);
            m_pc = m_pc + 13'h1;
            case (op)
                3'd1, 3'd2, 3'd7: begin
                    r = (op == 3'd1) ? f + 8'h1 : (op == 3'd2) ? (m_acc | f) : {f[6:0], m_c};
                    if (op == 3'd7) m_c = f[7];
                    else m_z = (r == 8'h00);
                    if (t) f = r;
                    else m_acc = r;
                end
                3'd3: m_acc = k;
                3'd4: begin
                    m_pc = m_top;
                    m_g = 1'b1;
                end
                3'd5: f = m_acc;
                3'd6: begin
                    m_acc = k;
                    m_pc = m_top;
                end
                default: ;
            endcase
            rd(ACC_OFS, {24'h0, m_acc}, 32'hff);
            rd(FLAGS_OFS, {28'h0, 1'b0, m_g, m_c, m_z}, 32'hf);
            rd(PC_OFS, {19'h0, m_pc}, 32'h1fff);
            wr(FILE_OFS, {17'h0, x, 8'h00});
            rd(FILE_OFS, {17'h0, x, f}, 32'h7fff);
            check({31'h0, irq_allow}, {31'h0, m_g});
        end
        complete_run();
    end
endmodule
